/* File: airc_ctrl.sv */
// Function
// - writes ignored unless top halfword is 0x5FA; top halfword reads 0xFA05
// - bit 15 reads fixed byte-order indicator, 0 little, 1 big
// - bits 10:8 hold read-write three-bit priority split point
// - writing 1 to bit 2 requests system reset; bit reads 0
// - reset request drives system reset of everything except debug logic
// - bits 1 and 0 read zero; software writes zero there
// - split g keeps bits 7:g+1 as group, g:0 as subpriority
// - split value 7 gives no group bits, all subpriority
// - missing low priority bits of narrow fields are taken as zero
// - preemption compares group priority portions only
`timescale 1ns/10ps
`default_nettype none

module airc_ctrl #(
  parameter bit BIG_ENDIAN = 1'b0,
  parameter int PRIO_BITS = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // priority comparison
  input wire logic [PRIO_BITS-1:0] i_prio_active,
  input wire logic [PRIO_BITS-1:0] i_prio_pending,
  output logic o_preempt,
  output logic [2:0] o_priority_split_point,
  // system reset request
  output logic o_system_reset_request
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (PRIO_BITS < 1 || PRIO_BITS > airc_pkg::PRIO_WIDTH) begin : g_bad_width
    $error("priority width must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // widen narrow field, low bits zero
  function automatic logic [7:0] airc_widen(input logic [PRIO_BITS-1:0] p);
    logic [7:0] w;
    w = '0;
    w[7 -: PRIO_BITS] = p;
    return w;
  endfunction : airc_widen

  // mask off subpriority bits
  function automatic logic [7:0] airc_group(input logic [7:0] p, input logic [2:0] g);
    logic [8:0] m;
    m = 9'h1FF << (9'(g) + 9'h001);
    return p & m[7:0];
  endfunction : airc_group

  typedef enum logic [0:0] {
    RST_IDLE = 1'b0,
    RST_PULSE = 1'b1
  } airc_rst_state_type;

  wire airc_pkg::airc_bus_req_type req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  logic sel;
  logic key_ok;
  logic [2:0] split_q;
  logic [31:0] rdata_q;
  logic reset_req_q;
  logic preempt_q;
  logic [1:0] pulse_cnt_q;
  airc_rst_state_type rst_state_q;
  airc_pkg::airc_compare_type cmp;

  assign sel = (req.addr == airc_pkg::AIRC_REG_OFFSET);
  assign key_ok = (req.wdata[airc_pkg::KEY_MSB:airc_pkg::KEY_LSB] == airc_pkg::UNLOCK_KEY_VALUE);

  // ----------------------------------------------------------------
  // split point register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      split_q <= airc_pkg::SPLIT_RESET;
    end else if (req.wr && sel && key_ok) begin
      split_q <= req.wdata[airc_pkg::SPLIT_MSB:airc_pkg::SPLIT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.rd && sel) begin
      rdata_q <= 32'h0000_0000;
      rdata_q[airc_pkg::KEY_MSB:airc_pkg::KEY_LSB] <= airc_pkg::KEY_STATUS_VALUE;
      rdata_q[airc_pkg::ENDIAN_BIT] <= BIG_ENDIAN;
      rdata_q[airc_pkg::SPLIT_MSB:airc_pkg::SPLIT_LSB] <= split_q;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // system reset request pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_state_q <= RST_IDLE;
      pulse_cnt_q <= 2'h0;
      reset_req_q <= 1'b0;
    end else begin
      case (rst_state_q)
        RST_IDLE: begin
          if (req.wr && sel && key_ok && req.wdata[airc_pkg::RESET_REQ_BIT]) begin
            rst_state_q <= RST_PULSE;
            pulse_cnt_q <= 2'(airc_pkg::RESET_PULSE_CYCLES - 1);
            reset_req_q <= 1'b1;
          end
        end
        RST_PULSE: begin
          if (pulse_cnt_q == 2'h0) begin
            rst_state_q <= RST_IDLE;
            reset_req_q <= 1'b0;
          end else begin
            pulse_cnt_q <= pulse_cnt_q - 2'h1;
          end
        end
        default: begin
          rst_state_q <= RST_IDLE;
          reset_req_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // preemption, group portions only
  // ----------------------------------------------------------------
  always_comb begin
    cmp.group_a = airc_group(airc_widen(i_prio_pending), split_q);
    cmp.group_b = airc_group(airc_widen(i_prio_active), split_q);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      preempt_q <= 1'b0;
    end else begin
      preempt_q <= (cmp.group_a < cmp.group_b);
    end
  end

  assign o_rdata = rdata_q;
  assign o_preempt = preempt_q;
  assign o_priority_split_point = split_q;
  assign o_system_reset_request = reset_req_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // widened priorities, checker use only
  logic [7:0] pend_w;
  logic [7:0] act_w;
  assign pend_w = airc_widen(i_prio_pending);
  assign act_w = airc_widen(i_prio_active);

  sequence s_bad_key_write;
    i_wr && sel && !key_ok;
  endsequence

  sequence s_keyed_write;
    i_wr && sel && key_ok;
  endsequence

  sequence s_reg_read;
    i_rd && sel;
  endsequence

  sequence s_reset_write;
    i_wr && sel && key_ok && i_wdata[airc_pkg::RESET_REQ_BIT] && rst_state_q == RST_IDLE;
  endsequence

  sequence s_pulse_high;
    o_system_reset_request [*2];
  endsequence

  sequence s_pulse_done;
    !o_system_reset_request;
  endsequence

  a_locked_write_kept: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_bad_key_write |=> $stable(split_q)
  ) else $error("write without key changed split");

  a_key_status_read: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_reg_read |=> o_rdata[airc_pkg::KEY_MSB:airc_pkg::KEY_LSB] == airc_pkg::KEY_STATUS_VALUE
  ) else $error("key status not read back");

  a_endian_read: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_reg_read |=> o_rdata[airc_pkg::ENDIAN_BIT] == BIG_ENDIAN
  ) else $error("byte order bit wrong");

  a_split_update: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_keyed_write |=> split_q == $past(i_wdata[airc_pkg::SPLIT_MSB:airc_pkg::SPLIT_LSB])
  ) else $error("split not stored");

  a_split_held: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !(i_wr && sel && key_ok) |=> $stable(split_q)
  ) else $error("split changed without keyed write");

  a_split_readback: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_reg_read |=> o_rdata[airc_pkg::SPLIT_MSB:airc_pkg::SPLIT_LSB] == $past(split_q)
  ) else $error("split not read back");

  a_reset_request: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_reset_write |=> s_pulse_high ##1 s_pulse_done
  ) else $error("reset request pulse wrong");

  a_reset_zero_write: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_wr && sel && key_ok && !i_wdata[airc_pkg::RESET_REQ_BIT] && rst_state_q == RST_IDLE
    |=> s_pulse_done
  ) else $error("reset requested by zero write");

  a_reset_bad_key: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_wr && sel && !key_ok && rst_state_q == RST_IDLE |=> s_pulse_done
  ) else $error("reset requested without key");

  a_pulse_bounded: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_system_reset_request) |=> o_system_reset_request ##1 s_pulse_done
  ) else $error("reset pulse length wrong");

  a_no_pulse_restart: assert property (
    @(posedge i_clk) disable iff (i_rst)
    rst_state_q == RST_PULSE && pulse_cnt_q == 2'h0 |=> s_pulse_done
  ) else $error("reset pulse restarted");

  a_zero_bits_read: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_reg_read |=> o_rdata[airc_pkg::RESET_REQ_BIT:0] == 3'h0
  ) else $error("low bits not zero");

  a_reserved_read: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_reg_read |=> o_rdata[airc_pkg::ENDIAN_BIT-1:airc_pkg::SPLIT_MSB+1] == 4'h0 &&
      o_rdata[airc_pkg::SPLIT_LSB-1:airc_pkg::RESET_REQ_BIT+1] == 5'h00
  ) else $error("reserved bits not zero");

  a_idle_rdata_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 32'h0000_0000
  ) else $error("read data without read strobe");

  a_other_addr_read: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_rd && !sel |=> o_rdata == 32'h0000_0000
  ) else $error("other address read not zero");

  a_all_sub_group: assert property (
    @(posedge i_clk) disable iff (i_rst)
    split_q == airc_pkg::SPLIT_ALL_SUB |=> !o_preempt
  ) else $error("preempt with no group bits");

  a_sub_ignored: assert property (
    @(posedge i_clk) disable iff (i_rst)
    split_q == 3'h4 && pend_w[7:5] == act_w[7:5] |=> !o_preempt
  ) else $error("subpriority caused preemption");

  a_equal_no_preempt: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_prio_pending == i_prio_active |=> !o_preempt
  ) else $error("equal priorities preempted");

  a_group_wins: assert property (
    @(posedge i_clk) disable iff (i_rst)
    split_q == 3'h0 && pend_w[7:1] < act_w[7:1] |=> o_preempt
  ) else $error("more urgent group did not preempt");

  a_top_group: assert property (
    @(posedge i_clk) disable iff (i_rst)
    split_q == 3'h6 && pend_w[7] < act_w[7] |=> o_preempt
  ) else $error("single group bit ignored");

endmodule : airc_ctrl

`default_nettype wire

/* File: airc_pkg.sv */
`default_nettype none

package airc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] AIRC_REG_OFFSET = 8'h00;
  localparam logic [15:0] UNLOCK_KEY_VALUE = 16'h05FA;
  localparam logic [15:0] KEY_STATUS_VALUE = 16'hFA05;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int KEY_LSB = 16;
  localparam int KEY_MSB = 31;
  localparam int ENDIAN_BIT = 15;
  localparam int SPLIT_LSB = 8;
  localparam int SPLIT_MSB = 10;
  localparam int RESET_REQ_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SPLIT_RESET = 3'h0;
  localparam logic [2:0] SPLIT_ALL_SUB = 3'h7;
  localparam int PRIO_WIDTH = 8;
  localparam int RESET_PULSE_NS = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_PULSE_CYCLES =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } airc_bus_req_type;

  typedef struct packed {
    logic [7:0] group_a;
    logic [7:0] group_b;
  } airc_compare_type;

endpackage : airc_pkg

`default_nettype wire

/* File: tb_interrupt_reset_control_reg.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_interrupt_reset_control_reg;
  // ----------------------------------------------------------------
  // clock, reset, design
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_prio_active = 8'h00;
  logic [7:0] i_prio_pending = 8'h00;
  logic [31:0] o_rdata;
  logic o_preempt;
  logic [2:0] o_priority_split_point;
  logic o_system_reset_request;
  logic rd_pend = 1'b0;
  logic pv = 1'b0;
  logic pre_pend = 1'b0;
  logic [31:0] exp_rd_q[$];
  logic exp_pre_q[$];
  int mismatches = 0;
  int n_compared = 0;

  always #4 i_clk = ~i_clk;

  airc_ctrl i_airc_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_prio_active(i_prio_active),
    .i_prio_pending(i_prio_pending), .o_preempt(o_preempt),
    .o_priority_split_point(o_priority_split_point),
    .o_system_reset_request(o_system_reset_request)
  );

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // results appear one cycle after their cause
  always @(posedge i_clk) begin
    rd_pend <= i_rd;
    pre_pend <= pv;
  end

  always @(negedge i_clk) begin
    if (rd_pend) chk("rdata", o_rdata, exp_rd_q.pop_front());
    if (pre_pend) chk("preempt", {31'h0, o_preempt}, {31'h0, exp_pre_q.pop_front()});
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_rd_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd

  task automatic req_levels(input logic [2:0] e);
    for (int k = 2; k >= 0; k--) begin
      @(negedge i_clk);
      chk("reset_req", {31'h0, o_system_reset_request}, {31'h0, e[k]});
    end
  endtask : req_levels

  // random priorities against the split now in force
  task automatic prio_run(input logic [2:0] g);
    logic [7:0] a;
    logic [7:0] p;
    for (int j = 0; j < 24; j++) begin
      @(posedge i_clk);
      a = 8'($urandom);
      p = (j % 4 == 0) ? (a ^ 8'h01) : 8'($urandom);
      i_prio_active <= a;
      i_prio_pending <= p;
      pv <= 1'b1;
      exp_pre_q.push_back(g == 3'h7 ? 1'b0 : ((p >> (g + 1)) < (a >> (g + 1))));
    end
    @(posedge i_clk);
    pv <= 1'b0;
  endtask : prio_run

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(34));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h00, 32'hFA05_0000);
    rd(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h05FB_0700);
    rd(8'h00, 32'hFA05_0000);
    for (int g = 0; g < 8; g++) begin
      wr(8'h00, {16'h05FA, 1'b1, 4'hF, 3'(g), 5'h1F, 3'h0});
      @(negedge i_clk);
      chk("split", {29'h0, o_priority_split_point}, 32'(g));
      rd(8'h00, {16'hFA05, 5'h00, 3'(g), 8'h00});
      prio_run(3'(g));
    end
    wr(8'h00, 32'h05FB_0004);
    req_levels(3'b000);
    wr(8'h00, 32'h05FA_0304);
    req_levels(3'b110);
    rd(8'h00, 32'hFA05_0300);
    repeat (3) @(posedge i_clk);
    conclude();
  end

  initial begin
    #50000;
    mismatches++;
    conclude();
  end
endmodule : tb_interrupt_reset_control_reg

`default_nettype wire
